// *** ccg_pkg.sv ***
// shared constants and types of the core and system clock generator
package ccg_pkg;
   // register map, byte addresses on the apb bus
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] STATUS_OFS = 12'h004;
   localparam logic [11:0] SLIPS_OFS = 12'h008;
   localparam int CTRL_DPLL_EN_BIT = 0;
   localparam logic CTRL_DPLL_EN_RST = 1'b1;
   localparam int ST_RATIO_LSB = 0;
   localparam int ST_DELAY_LSB = 4;
   localparam int ST_MODE_LSB = 8;
   localparam int ST_STABLE_BIT = 12;
   localparam int ST_LOCKED_BIT = 13;
   localparam int ST_REF_BIT = 14;
   localparam int ST_EQ_BIT = 15;
   localparam int ST_STATE_LSB = 16;
   localparam int SLIPS_W = 16;

   // clock mode codes
   localparam logic [2:0] MODE_NORMAL = 3'h0;
   localparam logic [2:0] MODE_CHIP_TEST = 3'h1;
   localparam logic [2:0] MODE_MODULE_TEST = 3'h2;
   localparam logic [2:0] MODE_INIT = 3'h3;
   localparam logic [2:0] MODE_FAST = 3'h5;
   localparam int MODE_EQ_BIT = 2;

   // prescaler terminal counts for divide by 1, 2 and 4
   localparam logic [1:0] PRESC_ONE = 2'h0;
   localparam logic [1:0] PRESC_TWO = 2'h1;
   localparam logic [1:0] PRESC_FOUR = 2'h3;

   // strap ranges and timing
   localparam logic [3:0] RATIO_MIN = 4'h3;
   localparam int SETTLE_CORE_CYC = 20;
   localparam int LOCK_RANGE_PPM = 3500;
   localparam int PPM_FULL = 1000000;
   localparam int SLIP_GAP_CYC =
      (PPM_FULL + LOCK_RANGE_PPM - 1) / LOCK_RANGE_PPM;
   localparam int REF_LOSS_CYC = 4096;

   typedef struct packed {
      logic [3:0] ratio;
      logic [2:0] delay;
   } ccg_strap_t;

   typedef enum logic [3:0] {
      DPLL_IDLE = 4'b0001,
      DPLL_ACQ_LOW = 4'b0010,
      DPLL_ACQ_HIGH = 4'b0100,
      DPLL_LOCK = 4'b1000
   } ccg_dpll_t;
endpackage : ccg_pkg

// *** ccg_sync.sv ***
// three-stage synchroniser that passes a change once stages two and three agree
module ccg_sync
   #(parameter int W = 1,
     parameter logic [W-1:0] IDLE = '0)
   (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // asynchronous input and filtered result
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
   );

   logic [W-1:0] st1;
   logic [W-1:0] st2;
   logic [W-1:0] st3;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         // start at the pin's idle level so release shows no false change
         st1 <= IDLE;
         st2 <= IDLE;
         st3 <= IDLE;
         q <= IDLE;
      end
      else
      begin
         st1 <= d;
         st2 <= st1;
         st3 <= st2;
         if (st2 == st3)
         begin
            q <= st3;
         end
      end
   end
endmodule : ccg_sync

// *** ccg_clock_gen.sv ***
// core clock, system clock divider, delayed copy and reference dpll
// Contract
// - delayed system clock copies primary, late by strapped whole core cycles
// - mode 000 gives core clock at half oscillator rate
// - mode 001 gives full-rate core clock with equalizer off
// - mode 010 gives core clock at quarter oscillator rate
// - mode 011 initialises core clock with equalizer on
// - mode 101 gives core clock at oscillator rate
// - mode msb set enables equalizer and full rate; clear disables it except in mode 011
// - ratio strapped from four request lines, valid 3 to 15
// - primary system clock is core clock divided by ratio
// - even ratio symmetric; odd ratio high one core cycle longer
// - delay 0 to 7 strapped; machine check msb, halt lsb
// - with reference present, primary clock is kept synchronised to it
// - coinciding edges stall core generator one oscillator cycle
// - primary stable 20 core cycles after straps settle
// - reference first sampled low: slip until high, then lock
// - reference first sampled high: no slip until low, then lock
// - before lock, slips add about 0.35 percent per period
//
// Our own choices: register access over APB and the address map.
module ccg_clock_gen
   #(parameter int REF_LOSS = ccg_pkg::REF_LOSS_CYC,
     parameter int SLIP_GAP = ccg_pkg::SLIP_GAP_CYC)
   (
   // apb slave; pclk doubles as the oscillator input
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // mode pins, power-up straps and reference clock
   input wire logic [2:0] clock_mode,
   input wire logic [3:0] ratio_strap,
   input wire logic halt_req,
   input wire logic power_fail_req,
   input wire logic machine_check_req,
   input wire logic reference_clock,
   // generated clocks and status
   output logic core_clock_tick,
   output logic equalizer_enable,
   output logic primary_system_clock,
   output logic primary_system_clock_n,
   output logic delayed_system_clock,
   output logic delayed_system_clock_n,
   output logic system_clock_stable,
   output logic dpll_locked
   );

   localparam int LOSS_W = $clog2(REF_LOSS + 1);
   localparam int GAP_W = $clog2(SLIP_GAP + 1);
   localparam int SETTLE_LAST = ccg_pkg::SETTLE_CORE_CYC - 1;

   logic [2:0] mode_q;
   ccg_pkg::ccg_strap_t strap_q;
   ccg_pkg::ccg_strap_t strap_prev;
   ccg_pkg::ccg_strap_t strap_cap;
   logic ref_q;

   ccg_sync #(.W(3)) u_mode_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d(clock_mode),
      .q(mode_q)
   );
   // strap order: ratio lines, then machine check, power fail, halt
   ccg_sync #(.W(7)) u_strap_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d({ratio_strap, machine_check_req, power_fail_req, halt_req}),
      .q(strap_q)
   );
   // an unused reference is tied high; a low reset would fake an edge
   ccg_sync #(.W(1), .IDLE(1'b1)) u_ref_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d(reference_clock),
      .q(ref_q)
   );

   // core clock prescaler
   logic [1:0] presc;
   logic [1:0] presc_top;
   logic core_run;
   logic slip_hold;
   logic next_tick;

   // msb set forces full rate whatever the low bits say
   assign presc_top = mode_q[ccg_pkg::MODE_EQ_BIT] ? ccg_pkg::PRESC_ONE :
      (mode_q == ccg_pkg::MODE_NORMAL) ? ccg_pkg::PRESC_TWO :
      (mode_q == ccg_pkg::MODE_MODULE_TEST) ? ccg_pkg::PRESC_FOUR :
      ccg_pkg::PRESC_ONE;
   // init mode parks the prescaler so the divider can restart cleanly
   assign core_run = mode_q != ccg_pkg::MODE_INIT;
   assign next_tick = core_run & ~slip_hold & (presc == presc_top);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         presc <= 2'h0;
         core_clock_tick <= 1'b0;
         equalizer_enable <= 1'b0;
      end
      else
      begin
         core_clock_tick <= next_tick;
         equalizer_enable <= mode_q[ccg_pkg::MODE_EQ_BIT] |
            (mode_q == ccg_pkg::MODE_INIT);
         if (!core_run)
         begin
            presc <= 2'h0;
         end
         else if (!slip_hold)
         begin
            presc <= (presc >= presc_top) ? 2'h0 : presc + 2'h1;
         end
      end
   end

   // strap settling and capture
   logic [4:0] settle_cnt;
   logic [3:0] ratio_ok;

   // codes below 3 are unsupported; clamp rather than run too fast
   assign ratio_ok = (strap_q.ratio < ccg_pkg::RATIO_MIN) ?
      ccg_pkg::RATIO_MIN : strap_q.ratio;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         strap_prev <= '0;
         strap_cap <= '0;
         settle_cnt <= 5'h0;
         system_clock_stable <= 1'b0;
      end
      else
      begin
         strap_prev <= strap_q;
         if (!system_clock_stable)
         begin
            if (strap_q != strap_prev)
            begin
               settle_cnt <= 5'h0;
            end
            else if (core_clock_tick)
            begin
               if (settle_cnt == 5'(SETTLE_LAST))
               begin
                  system_clock_stable <= 1'b1;
                  strap_cap.ratio <= ratio_ok;
                  strap_cap.delay <= strap_q.delay;
               end
               else
               begin
                  settle_cnt <= settle_cnt + 5'h1;
               end
            end
         end
      end
   end

   // system clock divider and delay line, both stepped by core ticks
   logic [3:0] sys_cnt;
   logic [3:0] next_cnt;
   logic [3:0] hi_len;
   logic sys_wrap;
   logic sys_rise;
   logic next_sys;
   logic [6:0] hist;
   logic [7:0] next_hist;
   logic sys_step;

   assign sys_step = core_clock_tick & system_clock_stable;
   assign sys_wrap = sys_cnt == (strap_cap.ratio - 4'h1);
   assign next_cnt = sys_wrap ? 4'h0 : sys_cnt + 4'h1;
   assign hi_len = 4'(({1'b0, strap_cap.ratio} + 5'h1) >> 1);
   assign next_sys = next_cnt < hi_len;
   assign sys_rise = sys_step & sys_wrap;
   // hist[0] is the primary clock itself, hist[n] is n core cycles old
   assign next_hist = {hist[6:0], next_sys};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sys_cnt <= 4'h0;
         hist <= 7'h0;
         primary_system_clock <= 1'b0;
         primary_system_clock_n <= 1'b1;
         delayed_system_clock <= 1'b0;
         delayed_system_clock_n <= 1'b1;
      end
      else if (sys_step)
      begin
         sys_cnt <= next_cnt;
         hist <= next_hist[6:0];
         primary_system_clock <= next_sys;
         primary_system_clock_n <= ~next_sys;
         delayed_system_clock <= next_hist[strap_cap.delay];
         delayed_system_clock_n <= ~next_hist[strap_cap.delay];
      end
   end

   // reference presence, phase slips and lock tracking
   ccg_pkg::ccg_dpll_t dstate;
   ccg_pkg::ccg_dpll_t next_dstate;
   logic ref_last;
   logic [LOSS_W-1:0] loss_cnt;
   logic [GAP_W-1:0] gap_cnt;
   logic ref_present;
   logic ctrl_dpll_en;
   logic dpll_go;
   logic slip_now;
   logic [ccg_pkg::SLIPS_W-1:0] slip_total;

   assign ref_present = loss_cnt != '0;
   assign dpll_go = ctrl_dpll_en & ref_present & system_clock_stable;
   // a reference at most 0.35 percent slower keeps lock slips rare
   assign slip_now = sys_rise & (
      ((dstate == ccg_pkg::DPLL_LOCK) & ref_q) |
      ((dstate == ccg_pkg::DPLL_ACQ_LOW) & ~ref_q & (gap_cnt == '0)));

   always_comb
   begin
      next_dstate = dstate;
      case (dstate)
         ccg_pkg::DPLL_IDLE:
            if (sys_rise)
            begin
               next_dstate = ref_q ? ccg_pkg::DPLL_ACQ_HIGH :
                  ccg_pkg::DPLL_ACQ_LOW;
            end
         ccg_pkg::DPLL_ACQ_LOW:
            if (sys_rise && ref_q)
            begin
               next_dstate = ccg_pkg::DPLL_LOCK;
            end
         ccg_pkg::DPLL_ACQ_HIGH:
            if (sys_rise && !ref_q)
            begin
               next_dstate = ccg_pkg::DPLL_LOCK;
            end
         ccg_pkg::DPLL_LOCK:
            next_dstate = ccg_pkg::DPLL_LOCK;
         default:
            next_dstate = ccg_pkg::DPLL_IDLE;
      endcase
      if (!dpll_go)
      begin
         next_dstate = ccg_pkg::DPLL_IDLE;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dstate <= ccg_pkg::DPLL_IDLE;
         dpll_locked <= 1'b0;
         ref_last <= 1'b1;
         loss_cnt <= '0;
         gap_cnt <= '0;
         slip_hold <= 1'b0;
         slip_total <= '0;
      end
      else
      begin
         dstate <= next_dstate;
         dpll_locked <= next_dstate == ccg_pkg::DPLL_LOCK;
         ref_last <= ref_q;
         if (ref_q != ref_last)
         begin
            loss_cnt <= LOSS_W'(REF_LOSS);
         end
         else if (ref_present)
         begin
            loss_cnt <= loss_cnt - 1'b1;
         end
         slip_hold <= slip_now;
         if (slip_now)
         begin
            gap_cnt <= GAP_W'(SLIP_GAP - 1);
            slip_total <= slip_total + 1'b1;
         end
         else if (gap_cnt != '0)
         begin
            gap_cnt <= gap_cnt - 1'b1;
         end
      end
   end

   // apb slave: zero wait, answer registered in the setup cycle
   logic setup;
   logic wr_ok;
   logic hit_ctrl;
   logic hit_status;
   logic hit_slips;
   logic mapped;
   logic [31:0] status_word;
   logic [31:0] rd_mux;

   assign setup = psel & ~penable;
   assign wr_ok = psel & penable & pready & pwrite;
   assign hit_ctrl = paddr == ccg_pkg::CTRL_OFS;
   assign hit_status = paddr == ccg_pkg::STATUS_OFS;
   assign hit_slips = paddr == ccg_pkg::SLIPS_OFS;
   assign mapped = hit_ctrl | hit_status | hit_slips;
   assign rd_mux = hit_ctrl ? {31'h0, ctrl_dpll_en} :
      hit_status ? status_word :
      hit_slips ? {16'h0, slip_total} : 32'h0;

   always_comb
   begin
      status_word = 32'h0;
      status_word[ccg_pkg::ST_RATIO_LSB +: 4] = strap_cap.ratio;
      status_word[ccg_pkg::ST_DELAY_LSB +: 3] = strap_cap.delay;
      status_word[ccg_pkg::ST_MODE_LSB +: 3] = mode_q;
      status_word[ccg_pkg::ST_STABLE_BIT] = system_clock_stable;
      status_word[ccg_pkg::ST_LOCKED_BIT] = dpll_locked;
      status_word[ccg_pkg::ST_REF_BIT] = ref_present;
      status_word[ccg_pkg::ST_EQ_BIT] = equalizer_enable;
      status_word[ccg_pkg::ST_STATE_LSB +: 4] = dstate;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
         ctrl_dpll_en <= ccg_pkg::CTRL_DPLL_EN_RST;
      end
      else
      begin
         pready <= setup;
         pslverr <= setup & ~mapped;
         prdata <= (setup & ~pwrite) ? rd_mux : 32'h0;
         if (wr_ok && hit_ctrl && pstrb[0])
         begin
            ctrl_dpll_en <= pwdata[ccg_pkg::CTRL_DPLL_EN_BIT];
         end
      end
   end

   // helper counters: core ticks per period and in the high phase
   logic [4:0] per_cnt;
   logic [4:0] hi_cnt;
   logic per_seen;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         per_cnt <= 5'h0;
         hi_cnt <= 5'h0;
         per_seen <= 1'b0;
      end
      else if (sys_step)
      begin
         per_cnt <= sys_rise ? 5'h1 : per_cnt + 5'h1;
         hi_cnt <= sys_rise ? 5'h1 : hi_cnt + {4'h0, next_sys};
         per_seen <= per_seen | sys_rise;
      end
   end

   a_core_half: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_q == ccg_pkg::MODE_NORMAL && $stable(mode_q) && core_clock_tick)
      |=> !core_clock_tick)
      else $error("core clock faster than half rate");
   a_core_quarter: assert property (@(posedge pclk)
      disable iff (!presetn)
      (mode_q == ccg_pkg::MODE_MODULE_TEST && $stable(mode_q)
       && core_clock_tick) |=> !core_clock_tick [*3])
      else $error("core clock faster than quarter rate");
   a_chip_eq_off: assert property (@(posedge pclk) disable iff (!presetn)
      mode_q == ccg_pkg::MODE_CHIP_TEST |=> !equalizer_enable)
      else $error("equalizer on in chip test mode");
   a_init_parks: assert property (@(posedge pclk) disable iff (!presetn)
      mode_q == ccg_pkg::MODE_INIT |=> equalizer_enable && !core_clock_tick)
      else $error("init mode did not park core clock");
   a_msb_full: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_q[2] && $past(mode_q[2]) && !slip_hold)
      |=> core_clock_tick && equalizer_enable)
      else $error("msb mode not at full rate");
   a_period_ratio: assert property (@(posedge pclk) disable iff (!presetn)
      (sys_rise && per_seen) |-> per_cnt == {1'b0, strap_cap.ratio})
      else $error("system clock period not equal to ratio");
   a_high_phase: assert property (@(posedge pclk) disable iff (!presetn)
      (sys_step && primary_system_clock && !next_sys && per_seen)
      |-> hi_cnt == 5'(strap_cap.ratio / 2 + strap_cap.ratio[0]))
      else $error("high phase length wrong");
   a_delay_zero: assert property (@(posedge pclk) disable iff (!presetn)
      strap_cap.delay == 3'h0 |-> delayed_system_clock == primary_system_clock)
      else $error("zero delay copy differs from primary");
   a_ratio_valid: assert property (@(posedge pclk) disable iff (!presetn)
      system_clock_stable |-> strap_cap.ratio >= ccg_pkg::RATIO_MIN)
      else $error("captured ratio below minimum");
   a_settle_time: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(system_clock_stable) |-> $past(settle_cnt) == 5'(SETTLE_LAST))
      else $error("stable flagged at wrong settle count");
   a_slip_stall: assert property (@(posedge pclk) disable iff (!presetn)
      slip_now |=> slip_hold ##1 !core_clock_tick)
      else $error("slip did not stall the core clock");
   a_high_no_slip: assert property (@(posedge pclk) disable iff (!presetn)
      (dstate == ccg_pkg::DPLL_ACQ_HIGH && sys_rise && ref_q && dpll_go)
      |=> dstate == ccg_pkg::DPLL_ACQ_HIGH && !slip_hold)
      else $error("slip while reference first sampled high");
   a_lock_holds: assert property (@(posedge pclk) disable iff (!presetn)
      (dstate == ccg_pkg::DPLL_LOCK && dpll_go) |=> dpll_locked)
      else $error("lock lost while reference present");
endmodule : ccg_clock_gen

// *** ccg_ref_model.sv ***
// reference clock source standing in for the shared system reference
module ccg_ref_model
   #(parameter real HALF_NS = 100.25)
   (
   // control from the bench
   input wire logic run,
   // reference seen by the block
   output logic reference_clock
   );
   timeunit 1ns;
   timeprecision 1ps;

   // an unused reference sits high, as if tied to the supply
   initial
   begin
      reference_clock = 1'b1;
      forever
      begin
         wait (run);
         // slightly slower than a ratio 4 primary at full rate
         #(HALF_NS) reference_clock = 1'b0;
         #(HALF_NS) reference_clock = 1'b1;
      end
   end
endmodule : ccg_ref_model

// *** tb_top.sv ***
// self-checking bench for the core and system clock generator
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb, ratio_strap;
   logic [2:0] clock_mode;
   logic halt_req, power_fail_req, machine_check_req, reference_clock;
   logic ref_run, core_clock_tick, equalizer_enable, system_clock_stable;
   logic primary_system_clock, primary_system_clock_n, dpll_locked;
   logic delayed_system_clock, delayed_system_clock_n;
   int fails, checks;

   ccg_clock_gen #(.REF_LOSS(64), .SLIP_GAP(8)) ccg_clock_gen_inst
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .clock_mode(clock_mode), .ratio_strap(ratio_strap),
      .halt_req(halt_req), .power_fail_req(power_fail_req),
      .machine_check_req(machine_check_req),
      .reference_clock(reference_clock),
      .core_clock_tick(core_clock_tick),
      .equalizer_enable(equalizer_enable),
      .primary_system_clock(primary_system_clock),
      .primary_system_clock_n(primary_system_clock_n),
      .delayed_system_clock(delayed_system_clock),
      .delayed_system_clock_n(delayed_system_clock_n),
      .system_clock_stable(system_clock_stable),
      .dpll_locked(dpll_locked)
   );

   ccg_ref_model ccg_ref_model_inst
   (
      .run(ref_run),
      .reference_clock(reference_clock)
   );

   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   task automatic test_done;
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : test_done

   task automatic give_up;
      fails++;
      test_done();
   endtask : give_up

   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_val

   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic err);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
         give_up();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // straps only count at power-up, so each set needs a fresh reset
   task automatic do_reset(input logic [2:0] m, input logic [3:0] r,
      input logic [2:0] dly);
      @(posedge pclk);
      presetn <= 1'b0;
      clock_mode <= m;
      ratio_strap <= r;
      {machine_check_req, power_fail_req, halt_req} <= dly;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
   endtask : do_reset

   task automatic wait_stable(output int ticks);
      int n;
      ticks = 0;
      n = 0;
      while (system_clock_stable !== 1'b1 && n < 2000)
      begin
         @(negedge pclk);
         if (core_clock_tick === 1'b1)
            ticks++;
         n++;
      end
      if (n >= 2000)
         give_up();
   endtask : wait_stable

   task automatic t_regs;
      logic [31:0] rd;
      logic err;
      do_reset(ccg_pkg::MODE_FAST, 4'h4, 3'h0);
      repeat (8) @(posedge pclk);
      apb(1'b0, ccg_pkg::CTRL_OFS, 32'h0, rd, err);
      check_val(rd, {31'h0, ccg_pkg::CTRL_DPLL_EN_RST});
      apb(1'b1, ccg_pkg::CTRL_OFS, 32'h0, rd, err);
      apb(1'b0, ccg_pkg::CTRL_OFS, 32'h0, rd, err);
      check_val(rd, 32'h0);
      apb(1'b1, ccg_pkg::CTRL_OFS, 32'h1, rd, err);
      apb(1'b1, ccg_pkg::STATUS_OFS, 32'hffff_ffff, rd, err);
      check_val(32'(err), 32'h0);
      apb(1'b0, ccg_pkg::STATUS_OFS, 32'h0, rd, err);
      check_val(32'({rd[15], rd[10:8]}), 32'hd);
      apb(1'b0, 12'h00c, 32'h0, rd, err);
      check_val(rd, 32'h0);
      check_val(32'(err), 32'h1);
      apb(1'b0, ccg_pkg::SLIPS_OFS, 32'h0, rd, err);
      check_val(rd, 32'h0);
   endtask : t_regs

   task automatic t_modes;
      logic [2:0] m[5] = '{ccg_pkg::MODE_NORMAL, ccg_pkg::MODE_MODULE_TEST,
         ccg_pkg::MODE_CHIP_TEST, ccg_pkg::MODE_FAST, ccg_pkg::MODE_INIT};
      int exp_ticks[5] = '{20, 10, 40, 40, 0};
      logic eq[5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
      int n;
      for (int i = 0; i < 5; i++)
      begin
         @(posedge pclk);
         clock_mode <= m[i];
         repeat (10) @(posedge pclk);
         n = 0;
         repeat (40)
         begin
            @(negedge pclk);
            if (core_clock_tick === 1'b1)
               n++;
         end
         check_val(32'(n), 32'(exp_ticks[i]));
         check_val(32'(equalizer_enable), 32'(eq[i]));
      end
   endtask : t_modes

   task automatic t_straps(input logic [3:0] r, input logic [2:0] d);
      logic [31:0] rd;
      logic err;
      logic [47:0] p, q;
      int ticks, nmis, dmis, k, hi, lo;
      do_reset(ccg_pkg::MODE_FAST, r, d);
      wait_stable(ticks);
      check_val(32'(ticks >= 20 && ticks <= 40), 32'h1);
      apb(1'b0, ccg_pkg::STATUS_OFS, 32'h0, rd, err);
      check_val(32'({rd[12], rd[6:0]}), 32'({1'b1, d, r}));
      nmis = 0;
      for (int i = 0; i < 48; i++)
      begin
         @(negedge pclk);
         p[i] = primary_system_clock;
         q[i] = delayed_system_clock;
         if (primary_system_clock_n !== ~primary_system_clock)
            nmis++;
         if (delayed_system_clock_n !== ~delayed_system_clock)
            nmis++;
      end
      check_val(32'(nmis), 32'h0);
      dmis = 0;
      for (int i = 8; i < 48; i++)
         if (q[i] !== p[i - d])
            dmis++;
      check_val(32'(dmis), 32'h0);
      k = 1;
      while (k < 20 && !(p[k - 1] === 1'b0 && p[k] === 1'b1))
         k++;
      hi = 0;
      lo = 0;
      while (k < 47 && p[k] === 1'b1)
      begin
         hi++;
         k++;
      end
      while (k < 47 && p[k] === 1'b0)
      begin
         lo++;
         k++;
      end
      check_val(32'(hi), 32'((r + 1) / 2));
      check_val(32'(lo), 32'(r / 2));
   endtask : t_straps

   task automatic t_dpll;
      logic [31:0] rd;
      logic err;
      int ticks, n;
      do_reset(ccg_pkg::MODE_FAST, 4'h4, 3'h3);
      wait_stable(ticks);
      ref_run <= 1'b1;
      n = 0;
      while (dpll_locked !== 1'b1 && n < 20000)
      begin
         @(negedge pclk);
         n++;
      end
      check_val(32'(dpll_locked), 32'h1);
      apb(1'b0, ccg_pkg::STATUS_OFS, 32'h0, rd, err);
      check_val(32'({rd[19:16], rd[14:13]}), 32'h23);
      repeat (3000) @(posedge pclk);
      apb(1'b0, ccg_pkg::SLIPS_OFS, 32'h0, rd, err);
      check_val(32'(rd[15:0] != 16'h0), 32'h1);
      check_val(32'(dpll_locked), 32'h1);
      ref_run <= 1'b0;
      repeat (400) @(posedge pclk);
      check_val(32'(dpll_locked), 32'h0);
   endtask : t_dpll

   initial
   begin
      repeat (100000) @(posedge pclk);
      give_up();
   end

   initial
   begin
      fails = 0;
      checks = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'hf;
      clock_mode = ccg_pkg::MODE_FAST;
      ratio_strap = 4'h4;
      halt_req = 1'b0;
      power_fail_req = 1'b0;
      machine_check_req = 1'b0;
      ref_run = 1'b0;
      t_regs();
      t_modes();
      t_straps(4'h3, 3'h0);
      t_straps(4'h4, 3'h7);
      t_straps(4'hf, 3'h5);
      t_straps(4'ha, 3'h2);
      t_dpll();
      test_done();
   end
endmodule : tb_top
